// ---- src/adc_ctl_params.svh ----
/*
 * Register offsets, field positions, reset values and interrupt layout of the
 * ADC calibration and channel 1 control block.
 * Assumes it is included by bare name once per compilation unit.
 */
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH

`define ADC_OFS_CFG      8'h01
`define ADC_OFS_CAL      8'h05
`define ADC_OFS_CH1      8'h06
`define ADC_OFS_CH1_LO   8'h07
`define ADC_OFS_CH1_HI   8'h08
`define ADC_OFS_CAL_LO   8'h14
`define ADC_OFS_CAL_HI   8'h15
`define ADC_OFS_IRQ_STS  8'h1a
`define ADC_OFS_IRQ_MSK  8'h1b

`define ADC_CFG_EN_BIT   0
`define ADC_CAL_HSV_BIT  5
`define ADC_CAL_GEV_BIT  4
`define ADC_CAL_HSS_BIT  1
`define ADC_CAL_GES_BIT  0
`define ADC_CH_VAL_BIT   7
`define ADC_CH_IEN_BIT   5

`define ADC_RES_W        14
`define ADC_BYTE_W       8
`define ADC_SEL_W        5
`define ADC_SEL_MAX      5'h0d
`define ADC_SEL_OFF      5'h1f

`define ADC_IRQ_W        3
`define ADC_IRQ_CONV     0
`define ADC_IRQ_HSCAL    1
`define ADC_IRQ_GECAL    2

`endif

// ---- src/adc_ctl_pkg.sv ----
/*
 * Types of the ADC calibration and channel 1 control block.
 * Assumes adc_ctl_params.svh is on the include path.
 */
`include "adc_ctl_params.svh"

package adc_ctl_pkg;

	// Gray coded along idle -> running -> idle
	typedef enum logic [1:0]
	{
		CAL_IDLE = 2'b00,
		CAL_HS   = 2'b01,
		CAL_GE   = 2'b10
	} cal_state_t;

	typedef struct packed
	{
		cal_state_t                 cal_st;
		logic                       conv_en;
		logic                       hs_start;
		logic                       ge_start;
		logic                       hs_valid;
		logic                       ge_valid;
		logic                       hs_req;
		logic                       ge_req;
		logic                       ch_valid;
		logic                       ch_irq_en;
		logic [`ADC_SEL_W-1:0]      sel;
		logic [`ADC_SEL_W-1:0]      sel_out;
		logic [`ADC_RES_W-1:0]      ch_data;
		logic [`ADC_RES_W-1:0]      cal_data;
		logic [`ADC_IRQ_W-1:0]      irq_sts;
		logic [`ADC_IRQ_W-1:0]      irq_msk;
		logic [7:0]                 rd_data;
		logic                       irq;
	} ctl_state_t;

endpackage : adc_ctl_pkg

// ---- src/adc_calib_and_channel_ctl.sv ----
/*
 * Calibration control and voltage channel 1 control for an ADC, with the
 * configuration enable, result buffers and a sticky interrupt status.
 * Assumes a converter core that pulses cal_done_i / conv_done_i for one
 * clock with the matching result word valid in that cycle, and a register
 * master with one-cycle strobes and read data taken the cycle after.
 */
`include "adc_ctl_params.svh"

module adc_calib_and_channel_ctl
(
	input  wire logic                   mclk_i,
	input  wire logic                   resetn_i,
	// Register port
	input  wire logic [7:0]             addr_i,
	input  wire logic [7:0]             wr_data_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [7:0]             rd_data_o,
	// Converter core side
	input  wire logic                   cal_done_i,
	input  wire logic [`ADC_RES_W-1:0]  cal_result_i,
	input  wire logic                   conv_done_i,
	input  wire logic [`ADC_RES_W-1:0]  conv_result_i,
	output logic                        conv_enable_o,
	output logic                        hs_cal_req_o,
	output logic                        ge_cal_req_o,
	output logic      [`ADC_SEL_W-1:0]  input_sel_o,
	// Interrupt
	output logic                        irq_o
);

	adc_ctl_pkg::ctl_state_t s_q;
	adc_ctl_pkg::ctl_state_t s_d;

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------

	// Selector codes 0..13 name a real input
	function automatic logic sel_is_input(input logic [`ADC_SEL_W-1:0] code);
		sel_is_input = (code <= `ADC_SEL_MAX);
	endfunction : sel_is_input

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Result words are read as a low byte and the upper bits in a second byte
	function automatic logic [7:0] lo_byte(input logic [`ADC_RES_W-1:0] w);
		lo_byte = w[`ADC_BYTE_W-1:0];
	endfunction : lo_byte

	function automatic logic [7:0] hi_byte(input logic [`ADC_RES_W-1:0] w);
		hi_byte = 8'(w >> `ADC_BYTE_W);
	endfunction : hi_byte

	logic wr_cfg;
	logic wr_cal;
	logic wr_ch1;
	logic wr_msk;
	logic rd_sts;

	assign wr_cfg = wr_i && hit(addr_i, `ADC_OFS_CFG);
	assign wr_cal = wr_i && hit(addr_i, `ADC_OFS_CAL);
	assign wr_ch1 = wr_i && hit(addr_i, `ADC_OFS_CH1);
	assign wr_msk = wr_i && hit(addr_i, `ADC_OFS_IRQ_MSK);
	assign rd_sts = rd_i && hit(addr_i, `ADC_OFS_IRQ_STS);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	always_comb
	begin
		logic                   en_n;
		logic                   conv_ok;
		logic [`ADC_IRQ_W-1:0]  ev;
		logic [`ADC_IRQ_W-1:0]  sts_clr;

		en_n    = s_q.conv_en;
		conv_ok = 1'b0;
		ev      = '0;
		sts_clr = '0;
		s_d     = s_q;

		// Converter enable
		// power gating
		if (wr_cfg)
		begin
			en_n = wr_data_i[`ADC_CFG_EN_BIT];
		end
		s_d.conv_en = en_n;

		// Calibration control writes; reserved bits 7..6 and 3..2 are dropped
		// write one clears
		if (wr_cal && wr_data_i[`ADC_CAL_HSV_BIT])
		begin
			s_d.hs_valid = 1'b0;
		end
		if (wr_cal && wr_data_i[`ADC_CAL_GEV_BIT])
		begin
			s_d.ge_valid = 1'b0;
		end
		if (wr_cal)
		begin
			s_d.hs_start = wr_data_i[`ADC_CAL_HSS_BIT];
			s_d.ge_start = wr_data_i[`ADC_CAL_GES_BIT];
		end

		// Channel 1 control writes
		// write one clears
		if (wr_ch1 && wr_data_i[`ADC_CH_VAL_BIT])
		begin
			s_d.ch_valid = 1'b0;
		end
		if (wr_ch1)
		begin
			s_d.ch_irq_en = wr_data_i[`ADC_CH_IEN_BIT];
			s_d.sel       = wr_data_i[`ADC_SEL_W-1:0];
		end

		// Calibration sequencer
		unique case (s_q.cal_st)
			adc_ctl_pkg::CAL_IDLE:
			begin
				if (s_q.conv_en && s_q.ge_start)
				begin
					s_d.cal_st = adc_ctl_pkg::CAL_GE;
				end
				else if (s_q.conv_en && s_q.hs_start)
				begin
					s_d.cal_st = adc_ctl_pkg::CAL_HS;
				end
			end
			adc_ctl_pkg::CAL_HS:
			begin
				if (cal_done_i)
				begin
					s_d.cal_data   = cal_result_i;
					s_d.hs_valid   = 1'b1;
					s_d.hs_start   = 1'b0;
					ev[`ADC_IRQ_HSCAL] = 1'b1;
					s_d.cal_st     = adc_ctl_pkg::CAL_IDLE;
				end
			end
			adc_ctl_pkg::CAL_GE:
			begin
				if (cal_done_i)
				begin
					s_d.cal_data   = cal_result_i;
					s_d.hs_valid   = 1'b1;
					s_d.ge_valid   = 1'b1;
					s_d.ge_start   = 1'b0;
					ev[`ADC_IRQ_GECAL] = 1'b1;
					s_d.cal_st     = adc_ctl_pkg::CAL_IDLE;
				end
			end
			default:
			begin
				s_d.cal_st = adc_ctl_pkg::CAL_IDLE;
			end
		endcase

		// End of conversion on channel 1
		// set at end of conversion
		conv_ok = conv_done_i && s_q.conv_en && sel_is_input(s_q.sel);
		if (conv_ok)
		begin
			s_d.ch_data  = conv_result_i;
			s_d.ch_valid = 1'b1;
			ev[`ADC_IRQ_CONV] = 1'b1;
		end

		// Disable wipes flags and any calibration in flight
		// Clear beats any set in the same cycle, so no valid flag sets while off; irq_sts keeps its bits
		// cleared by disable
		if (!en_n)
		begin
			s_d.hs_valid = 1'b0;
			s_d.ge_valid = 1'b0;
			s_d.ch_valid = 1'b0;
			s_d.hs_start = 1'b0;
			s_d.ge_start = 1'b0;
			s_d.cal_st   = adc_ctl_pkg::CAL_IDLE;
		end

		// Converter requests follow the sequencer's next state
		s_d.hs_req = (s_d.cal_st == adc_ctl_pkg::CAL_HS);
		s_d.ge_req = (s_d.cal_st == adc_ctl_pkg::CAL_GE);

		// Reserved codes are never passed on as an input
		// selector decode
		s_d.sel_out = sel_is_input(s_d.sel) ? s_d.sel : `ADC_SEL_OFF;

		// Sticky status: a read clears, but an event in that cycle survives
		if (rd_sts)
		begin
			sts_clr = '1;
		end
		s_d.irq_sts = (s_q.irq_sts & ~sts_clr) | ev;
		if (wr_msk)
		begin
			s_d.irq_msk = wr_data_i[`ADC_IRQ_W-1:0];
		end

		// Level output: stays high until software removes its cause
		// channel valid interrupt
		s_d.irq = (s_d.ch_valid && s_d.ch_irq_en) || (|(s_d.irq_sts & s_d.irq_msk));

		// Read data, unmapped addresses answer zero
		s_d.rd_data = 8'h00;
		if (rd_i)
		begin
			unique case (addr_i)
				`ADC_OFS_CFG:
				begin
					s_d.rd_data[`ADC_CFG_EN_BIT] = s_q.conv_en;
				end
				`ADC_OFS_CAL:
				begin
					s_d.rd_data[`ADC_CAL_HSV_BIT] = s_q.hs_valid;
					s_d.rd_data[`ADC_CAL_GEV_BIT] = s_q.ge_valid;
					s_d.rd_data[`ADC_CAL_HSS_BIT] = s_q.hs_start;
					s_d.rd_data[`ADC_CAL_GES_BIT] = s_q.ge_start;
				end
				`ADC_OFS_CH1:
				begin
					s_d.rd_data[`ADC_CH_VAL_BIT]  = s_q.ch_valid;
					s_d.rd_data[`ADC_CH_IEN_BIT]  = s_q.ch_irq_en;
					s_d.rd_data[`ADC_SEL_W-1:0]   = s_q.sel;
				end
				`ADC_OFS_CH1_LO:
				begin
					s_d.rd_data = lo_byte(s_q.ch_data);
				end
				`ADC_OFS_CH1_HI:
				begin
					s_d.rd_data = hi_byte(s_q.ch_data);
				end
				`ADC_OFS_CAL_LO:
				begin
					s_d.rd_data = lo_byte(s_q.cal_data);
				end
				`ADC_OFS_CAL_HI:
				begin
					s_d.rd_data = hi_byte(s_q.cal_data);
				end
				`ADC_OFS_IRQ_STS:
				begin
					s_d.rd_data[`ADC_IRQ_W-1:0] = s_q.irq_sts;
				end
				`ADC_OFS_IRQ_MSK:
				begin
					s_d.rd_data[`ADC_IRQ_W-1:0] = s_q.irq_msk;
				end
				default:
				begin
					s_d.rd_data = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			s_q           <= '0;
			s_q.cal_st    <= adc_ctl_pkg::CAL_IDLE;
			s_q.sel       <= `ADC_SEL_OFF;
			s_q.sel_out   <= `ADC_SEL_OFF;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, each straight from the state register
	// ------------------------------------------------------------------

	assign rd_data_o     = s_q.rd_data;
	assign conv_enable_o = s_q.conv_en;
	assign hs_cal_req_o  = s_q.hs_req;
	assign ge_cal_req_o  = s_q.ge_req;
	assign input_sel_o   = s_q.sel_out;
	assign irq_o         = s_q.irq;

endmodule : adc_calib_and_channel_ctl

// ---- testbench/adc_ctl_props.sv ----
/* Port assertions for the ADC calibration and channel 1 control block.
 * Assumes it is bound onto adc_calib_and_channel_ctl. */
`include "adc_ctl_params.svh"
module adc_ctl_props
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rd_data_o,
	input wire logic cal_done_i,
	input wire logic conv_enable_o,
	input wire logic hs_cal_req_o,
	input wire logic ge_cal_req_o,
	input wire logic [`ADC_SEL_W-1:0] input_sel_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	logic idle;
	logic cal_wr;
	assign idle = conv_enable_o && !hs_cal_req_o && !ge_cal_req_o;
	assign cal_wr = wr_i && addr_i == `ADC_OFS_CAL;
	a_rd_idle_zero: assert property ( // quiet bus
		!$past(rd_i) |-> rd_data_o == 8'h00) else $error("read data outside a read");
	a_req_single: assert property ( // one run
		!(hs_cal_req_o && ge_cal_req_o)) else $error("two calibrations at once");
	a_req_needs_en: assert property ( // power down
		!conv_enable_o |=> !hs_cal_req_o && !ge_cal_req_o) else $error("run while off");
	a_ge_drop: assert property ( // self clear
		ge_cal_req_o && cal_done_i |=> !ge_cal_req_o) else $error("gain run stuck");
	a_hs_drop: assert property ( // self clear
		hs_cal_req_o && cal_done_i |=> !hs_cal_req_o) else $error("high-scale run stuck");
	a_ge_start: assert property ( // gain start
		cal_wr && wr_data_i[0] && idle |-> ##2 ge_cal_req_o) else $error("gain run late");
	a_hs_start: assert property ( // scale start
		cal_wr && wr_data_i[1:0] == 2'b10 && idle |-> ##2 hs_cal_req_o)
		else $error("high-scale run late");
	a_sel_legal: assert property ( // legal codes
		input_sel_o <= `ADC_SEL_MAX || input_sel_o == `ADC_SEL_OFF) else $error("bad select");
	a_en_write: assert property ( // enable write
		wr_i && addr_i == `ADC_OFS_CFG |=> conv_enable_o == $past(wr_data_i[0]))
		else $error("enable not written");
	c_ge_run: cover property ($rose(ge_cal_req_o));
	c_hs_run: cover property ($rose(hs_cal_req_o));
	c_irq: cover property ($rose(irq_o));
endmodule : adc_ctl_props

bind adc_calib_and_channel_ctl adc_ctl_props i_props (.mclk_i, .resetn_i, .addr_i,
	.wr_data_i, .wr_i, .rd_i, .rd_data_o, .cal_done_i, .conv_enable_o, .hs_cal_req_o,
	.ge_cal_req_o, .input_sel_o, .irq_o);

// ---- testbench/adc_core_model.sv ----
/* Behavioural converter core facing the ADC control block.
 * Assumes the control block's enable, request and select outputs. */
`include "adc_ctl_params.svh"
module adc_core_model
(
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic hs_i,
	input wire logic ge_i,
	input wire logic go_i,
	input wire logic [`ADC_SEL_W-1:0] sel_i,
	output logic cdone_o,
	output logic [`ADC_RES_W-1:0] cres_o,
	output logic vdone_o,
	output logic [`ADC_RES_W-1:0] vres_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt = 4'h0;
	logic [2:0] vcnt = 3'h0;
	initial
	begin
		{cdone_o, vdone_o, cres_o, vres_o} = '0;
	end
	always @(posedge clk_i)
	begin
		cdone_o <= 1'b0;
		vdone_o <= 1'b0;
		// Idle result lines toggle so stale data never looks valid
		cres_o <= ~cres_o;
		vres_o <= ~vres_o;
		cnt <= (en_i && (hs_i || ge_i) && !cdone_o) ? cnt + 4'h1 : 4'h0;
		if (cnt == 4'h9)
		begin
			cdone_o <= 1'b1;
			cres_o <= ge_i ? 14'h1b6c : 14'h0e93;
		end
		vcnt <= go_i ? 3'h1 : (vcnt == 3'h0 ? 3'h0 : vcnt + 3'h1);
		// A powered-down core or an unselected input gives no result
		if (vcnt == 3'h4 && en_i && sel_i <= `ADC_SEL_MAX)
		begin
			vdone_o <= 1'b1;
			vres_o <= {9'h150, sel_i};
		end
	end
endmodule : adc_core_model

// ---- testbench/tb_top.sv ----
/* Self-checking bench for the ADC calibration and channel 1 control.
 * Assumes the converter core model and the bound checker. */
`include "adc_ctl_params.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_t;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wr_data_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic go = 1'b0;
	logic [7:0] rd_data_o;
	logic [7:0] v;
	logic cal_done_i, conv_done_i, conv_enable_o, hs_cal_req_o, ge_cal_req_o, irq_o;
	logic [13:0] cal_result_i, conv_result_i;
	logic [4:0] input_sel_o;
	int err_count = 0;
	int n_compared = 0;
	row_t rows [8] = '{'{8'h06, 8'h2d, 8'h2d}, '{8'h06, 8'h4c, 8'h0c}, '{8'h05, 8'hcc, 8'h00},
		'{8'h1b, 8'hff, 8'h07}, '{8'h1b, 8'h00, 8'h00}, '{8'h3f, 8'hff, 8'h00},
		'{8'h01, 8'hfe, 8'h00}, '{8'h01, 8'h01, 8'h01}};
	always #50 mclk_i = ~mclk_i;
	adc_calib_and_channel_ctl i_dut (.mclk_i, .resetn_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
		.rd_data_o, .cal_done_i, .cal_result_i, .conv_done_i, .conv_result_i, .conv_enable_o,
		.hs_cal_req_o, .ge_cal_req_o, .input_sel_o, .irq_o);
	adc_core_model i_core (.clk_i(mclk_i), .en_i(conv_enable_o), .hs_i(hs_cal_req_o),
		.ge_i(ge_cal_req_o), .go_i(go), .sel_i(input_sel_o), .cdone_o(cal_done_i),
		.cres_o(cal_result_i), .vdone_o(conv_done_i), .vres_o(conv_result_i));
	task wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected at %0t: got %h, want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(negedge mclk_i);
		chk(rd_data_o, e);
	endtask : rc
	// Pulse a conversion or wait out a calibration, bounded
	task wt(input bit conv);
		int i;
		go <= conv;
		repeat (3) @(posedge mclk_i);
		go <= 1'b0;
		for (i = 0; i < 50 && (conv ? !conv_done_i : hs_cal_req_o || ge_cal_req_o); i++)
			@(posedge mclk_i);
		if (i == 50)
		begin
			err_count++;
			wrap_up();
		end
		repeat (2) @(posedge mclk_i);
	endtask : wt
	task ck_irq(input logic e);
		repeat (2) @(negedge mclk_i);
		chk({7'h0, irq_o}, {7'h0, e}); // irq level
	endtask : ck_irq
	initial
	begin
		repeat (10) @(posedge mclk_i);
		resetn_i <= 1'b1;
		rc(`ADC_OFS_CH1, 8'h1f); // select off
		rc(`ADC_OFS_CAL, 8'h00); // flags clear
		rc(`ADC_OFS_CFG, 8'h00); // core off
		$display("reset test done");
		foreach (rows[k])
		begin
			wr(rows[k].a, rows[k].w);
			rc(rows[k].a, rows[k].r); // reserved bits
		end
		for (int c = 0; c < 32; c++)
		begin
			wr(`ADC_OFS_CH1, 8'(c));
			repeat (3) @(negedge mclk_i);
			chk({3'h0, input_sel_o}, c <= 13 ? 8'(c) : 8'h1f); // codes
		end
		$display("table test done");
		wr(`ADC_OFS_CH1, 8'h0d);
		wr(`ADC_OFS_IRQ_MSK, 8'h01);
		wr(`ADC_OFS_CAL, 8'h01);
		wt(1'b0);
		rc(`ADC_OFS_CAL, 8'h30); // both flags
		rc(`ADC_OFS_CAL_LO, 8'h6c); // gain result
		rc(`ADC_OFS_CAL_HI, 8'h1b); // gain result
		ck_irq(1'b0); // masked out
		wr(`ADC_OFS_CAL, 8'h10);
		rc(`ADC_OFS_CAL, 8'h20); // write one
		wr(`ADC_OFS_CAL, 8'h22);
		wt(1'b0);
		rc(`ADC_OFS_CAL, 8'h20); // start cleared
		rc(`ADC_OFS_CAL_LO, 8'h93); // offset result
		rc(`ADC_OFS_CAL_HI, 8'h0e); // offset result
		rc(`ADC_OFS_IRQ_STS, 8'h06); // events logged
		rc(`ADC_OFS_IRQ_STS, 8'h00); // read clears
		$display("calibration test done");
		// Selector was set before the measurement starts
		wt(1'b1); // select first
		rc(`ADC_OFS_CH1, 8'h8d); // valid set
		rc(`ADC_OFS_CH1_LO, 8'h0d); // low byte
		rc(`ADC_OFS_CH1_HI, 8'h2a); // high bits
		ck_irq(1'b1); // status path
		rc(`ADC_OFS_IRQ_STS, 8'h01); // status read
		ck_irq(1'b0); // enable off
		wr(`ADC_OFS_CH1, 8'h2d);
		ck_irq(1'b1); // enable on
		wr(`ADC_OFS_CH1, 8'had);
		ck_irq(1'b0); // write one
		rc(`ADC_OFS_CH1, 8'h2d); // write one
		wt(1'b1);
		wr(`ADC_OFS_CFG, 8'h00);
		rc(`ADC_OFS_CH1, 8'h2d); // off clears
		rc(`ADC_OFS_CAL, 8'h00); // off clears
		chk({7'h0, conv_enable_o}, 8'h00); // power down
		$display("conversion test done");
		wrap_up();
	end
endmodule : tb_top
